// ===== hdl/lfc_core.sv
`timescale 1ns/100ps
// How it works
// - Serial clock idle in active mode: shutdown
// - Idle shutdown restores configuration defaults
// - Mode select zero, no torch: standby
// - Output enable picks indicator, assist, flash
// - Torch and assist use seven low bits
// - Indicator uses six bits, PWM duty
// - Flash starts on enable or trigger edge
// - Level trigger: flash while pin high
// - Mask pin lowers flash to reduced level
// - Pre-start low battery: flag, maybe abort
// - Pre-start low battery without abort: reduced level
// - Running low battery steps current down
// - Each current step takes 8 microseconds
// - Present current readable during flash
// - Lowest current held after flash
// - Fault flags clear on fault read
// - Serial clock high releases shutdown at once
module lfc_core #(
   parameter int IDLE_CYCLES = lfc_pkg::IDLE_CYCLES,
   parameter int FLASH_UNIT_CYCLES = lfc_pkg::FLASH_UNIT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_in,
   input wire logic trigger_in,
   input wire logic mask_torch_in,
   input wire logic vin_pre_low_in,
   input wire logic vin_run_low_in,
   output logic [7:0] current_sink_outputs,
   output logic sink_on,
   output logic [2:0] op_mode
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic out_on;
      logic [1:0] mode_sel;
      logic [1:0] pin_fn;
      logic strobe_on;
      logic strobe_type;
      logic abort_sel;
      logic [7:0] led_cur;
      logic [7:0] mask_cur;
      logic [7:0] limit;
      logic [3:0] duty;
      lfc_pkg::lfc_mode_type mode;
      logic [7:0] actual;
      logic [7:0] minimum;
      logic ramp_done;
      logic reduced;
      logic [31:0] idle_cnt;
      logic shutdown;
      logic [31:0] unit_cnt;
      logic [7:0] units;
      logic [15:0] step_cnt;
      logic trig_prev;
      logic flt_uvlo;
      logic flt_timeout;
      logic flt_mask;
      logic [31:0] rdata;
      logic [7:0] sink_code;
      logic sink_en;
   } lfc_core_type;

   lfc_core_type st_ff;
   lfc_core_type nxt_st;
   lfc_pin_if pins();
   logic pwm_on;
   logic setup_rd;
   logic acc;
   logic mapped;
   logic step_tick;
   logic want_flash;
   logic start;
   logic timed_out;
   logic level_end;
   logic [7:0] target;

   // ---------------------------------------------------------------
   // Pin synchroniser and indicator PWM
   // ---------------------------------------------------------------
   lfc_pin_sync #(.W(5)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .raw({vin_run_low_in, vin_pre_low_in, mask_torch_in, trigger_in, scl_in}),
      .pins(pins.sync_side)
   );

   lfc_pwm u_pwm (
      .ref_clk(ref_clk),
      .rst(rst),
      .duty(st_ff.duty),
      .pwm_on(pwm_on)
   );

   // ---------------------------------------------------------------
   // APB decode
   // ---------------------------------------------------------------
   assign mapped = (paddr == lfc_pkg::CTRL_OFS) || (paddr == lfc_pkg::CURRENT_OFS) ||
      (paddr == lfc_pkg::TIMING_OFS) || (paddr == lfc_pkg::STATUS_OFS) ||
      (paddr == lfc_pkg::FAULT_OFS);
   assign setup_rd = psel && !penable && !pwrite;
   assign acc = psel && penable;
   assign pready = 1'b1; // Read data is latched in setup, so no wait states
   assign pslverr = acc && !mapped;
   assign prdata = st_ff.rdata;

   // Timing helpers
   assign step_tick = (st_ff.step_cnt == 16'(lfc_pkg::STEP_CYCLES - 1));
   assign want_flash = !st_ff.shutdown && st_ff.out_on &&
      (st_ff.mode_sel == lfc_pkg::MODE_FLASH);
   assign start = !st_ff.strobe_on ||
      (st_ff.strobe_type ? pins.trig : (pins.trig && !st_ff.trig_prev));
   assign timed_out = (st_ff.units == st_ff.limit) &&
      (st_ff.unit_cnt == 32'(FLASH_UNIT_CYCLES - 1));
   assign level_end = st_ff.strobe_on && st_ff.strobe_type && !pins.trig;
   assign target = (st_ff.reduced || ((st_ff.pin_fn == lfc_pkg::PIN_FN_MASK) && pins.mask)) ?
      st_ff.mask_cur : st_ff.led_cur;

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.trig_prev = pins.trig;
      nxt_st.step_cnt = step_tick ? 16'h0000 : st_ff.step_cnt + 16'h0001;

      // Read data is captured in the setup phase
      if (setup_rd) begin
         nxt_st.rdata = 32'h0000_0000;
         case (paddr)
            lfc_pkg::CTRL_OFS: begin
               nxt_st.rdata[lfc_pkg::CTRL_OUT_ON_POS] = st_ff.out_on;
               nxt_st.rdata[lfc_pkg::CTRL_MODE_POS +: 2] = st_ff.mode_sel;
               nxt_st.rdata[lfc_pkg::CTRL_PIN_FN_POS +: 2] = st_ff.pin_fn;
               nxt_st.rdata[lfc_pkg::CTRL_STROBE_ON_POS] = st_ff.strobe_on;
               nxt_st.rdata[lfc_pkg::CTRL_STROBE_TYPE_POS] = st_ff.strobe_type;
               nxt_st.rdata[lfc_pkg::CTRL_ABORT_POS] = st_ff.abort_sel;
            end
            lfc_pkg::CURRENT_OFS: begin
               nxt_st.rdata[lfc_pkg::CUR_LED_POS +: 8] = st_ff.led_cur;
               nxt_st.rdata[lfc_pkg::CUR_MASK_POS +: 8] = st_ff.mask_cur;
            end
            lfc_pkg::TIMING_OFS: begin
               nxt_st.rdata[lfc_pkg::TIM_LIMIT_POS +: 8] = st_ff.limit;
               nxt_st.rdata[lfc_pkg::TIM_DUTY_POS +: 4] = st_ff.duty;
            end
            lfc_pkg::STATUS_OFS: begin
               nxt_st.rdata[lfc_pkg::STAT_ACTUAL_POS +: 8] = st_ff.actual;
               nxt_st.rdata[lfc_pkg::STAT_MIN_POS +: 8] = st_ff.minimum;
               nxt_st.rdata[lfc_pkg::STAT_MODE_POS +: 3] = st_ff.mode;
            end
            lfc_pkg::FAULT_OFS: begin
               nxt_st.rdata[lfc_pkg::FLT_UVLO_POS] = st_ff.flt_uvlo;
               nxt_st.rdata[lfc_pkg::FLT_TIMEOUT_POS] = st_ff.flt_timeout;
               nxt_st.rdata[lfc_pkg::FLT_MASK_POS] = st_ff.flt_mask;
            end
            default: begin
               nxt_st.rdata = 32'h0000_0000;
            end
         endcase
      end

      // Register writes and read side effects take place at the access phase
      if (acc && pwrite && (paddr == lfc_pkg::CTRL_OFS)) begin
         nxt_st.out_on = pwdata[lfc_pkg::CTRL_OUT_ON_POS];
         nxt_st.mode_sel = pwdata[lfc_pkg::CTRL_MODE_POS +: 2];
         nxt_st.pin_fn = pwdata[lfc_pkg::CTRL_PIN_FN_POS +: 2];
         nxt_st.strobe_on = pwdata[lfc_pkg::CTRL_STROBE_ON_POS];
         nxt_st.strobe_type = pwdata[lfc_pkg::CTRL_STROBE_TYPE_POS];
         nxt_st.abort_sel = pwdata[lfc_pkg::CTRL_ABORT_POS];
      end
      if (acc && pwrite && (paddr == lfc_pkg::CURRENT_OFS)) begin
         nxt_st.led_cur = pwdata[lfc_pkg::CUR_LED_POS +: 8];
         nxt_st.mask_cur = pwdata[lfc_pkg::CUR_MASK_POS +: 8];
      end
      if (acc && pwrite && (paddr == lfc_pkg::TIMING_OFS)) begin
         nxt_st.limit = pwdata[lfc_pkg::TIM_LIMIT_POS +: 8];
         nxt_st.duty = pwdata[lfc_pkg::TIM_DUTY_POS +: 4];
      end
      // Cleared first so that an event in the same cycle sets the flag again
      if (acc && !pwrite && (paddr == lfc_pkg::FAULT_OFS)) begin
         nxt_st.flt_uvlo = 1'b0;
         nxt_st.flt_timeout = 1'b0;
         nxt_st.flt_mask = 1'b0;
      end

      // Serial clock watchdog; a high level ends shutdown at once
      if (pins.scl) begin
         nxt_st.idle_cnt = 32'h0000_0000;
         nxt_st.shutdown = 1'b0;
      end else if (st_ff.out_on && (st_ff.mode_sel != 2'h0) && !st_ff.shutdown) begin
         if (st_ff.idle_cnt == 32'(IDLE_CYCLES - 1)) begin
            nxt_st.idle_cnt = 32'h0000_0000;
            nxt_st.shutdown = 1'b1;
            nxt_st.out_on = 1'b0;
            nxt_st.mode_sel = lfc_pkg::MODE_RST;
            nxt_st.pin_fn = lfc_pkg::PIN_FN_RST;
            nxt_st.strobe_on = 1'b0;
            nxt_st.strobe_type = 1'b0;
            nxt_st.abort_sel = 1'b0;
            nxt_st.led_cur = lfc_pkg::LED_CUR_RST;
            nxt_st.mask_cur = lfc_pkg::MASK_CUR_RST;
            nxt_st.limit = lfc_pkg::LIMIT_RST;
            nxt_st.duty = lfc_pkg::DUTY_RST;
         end else begin
            nxt_st.idle_cnt = st_ff.idle_cnt + 32'h0000_0001;
         end
      end else begin
         nxt_st.idle_cnt = 32'h0000_0000;
      end

      // Mode selection from the registered configuration and pins
      if (st_ff.shutdown) begin
         nxt_st.mode = lfc_pkg::M_SHUTDOWN;
      end else if (!st_ff.out_on || (st_ff.mode_sel == 2'h0)) begin
         if ((st_ff.mode_sel == 2'h0) && (st_ff.pin_fn == lfc_pkg::PIN_FN_TORCH) && pins.mask) begin
            nxt_st.mode = lfc_pkg::M_TORCH;
         end else begin
            nxt_st.mode = lfc_pkg::M_STANDBY;
         end
      end else if (st_ff.mode_sel == lfc_pkg::MODE_IND) begin
         nxt_st.mode = lfc_pkg::M_INDICATOR;
      end else if (st_ff.mode_sel == lfc_pkg::MODE_ASSIST) begin
         nxt_st.mode = lfc_pkg::M_ASSIST;
      end else if (st_ff.mode != lfc_pkg::M_FLASH_ON) begin
         nxt_st.mode = lfc_pkg::M_FLASH_ARM;
      end

      // Flash start with the pre-start battery check
      if (want_flash && (st_ff.mode == lfc_pkg::M_FLASH_ARM) && start) begin
         nxt_st.actual = 8'h00;
         nxt_st.minimum = st_ff.led_cur;
         nxt_st.ramp_done = 1'b0;
         nxt_st.reduced = 1'b0;
         nxt_st.units = 8'h00;
         nxt_st.unit_cnt = 32'h0000_0000;
         nxt_st.mode = lfc_pkg::M_FLASH_ON;
         if (pins.vin_pre_low) begin
            nxt_st.flt_uvlo = 1'b1;
            if (st_ff.abort_sel) begin
               nxt_st.out_on = 1'b0;
               nxt_st.mode = lfc_pkg::M_STANDBY;
            end else begin
               nxt_st.reduced = 1'b1;
            end
         end
      end

      // Running flash: duration, ramp and battery reductions
      if (want_flash && (st_ff.mode == lfc_pkg::M_FLASH_ON)) begin
         if (st_ff.unit_cnt == 32'(FLASH_UNIT_CYCLES - 1)) begin
            nxt_st.unit_cnt = 32'h0000_0000;
            nxt_st.units = st_ff.units + 8'h01;
         end else begin
            nxt_st.unit_cnt = st_ff.unit_cnt + 32'h0000_0001;
         end
         if ((st_ff.pin_fn == lfc_pkg::PIN_FN_MASK) && pins.mask) begin
            nxt_st.flt_mask = 1'b1;
            if (st_ff.actual > st_ff.mask_cur) begin
               nxt_st.actual = st_ff.mask_cur;
            end
         end
         // One code step per 8 us tick; a low battery halts the ramp
         if (step_tick) begin
            if (pins.vin_run_low) begin
               nxt_st.flt_uvlo = 1'b1;
               if (st_ff.ramp_done && (st_ff.actual != 8'h00)) begin
                  nxt_st.actual = st_ff.actual - 8'h01;
               end
            end else if (!st_ff.ramp_done) begin
               if (st_ff.actual < target) begin
                  nxt_st.actual = st_ff.actual + 8'h01;
               end
               // Done once the target is met, so a sag at the next tick steps down
               nxt_st.ramp_done = (nxt_st.actual >= target);
            end else if (st_ff.actual > target) begin
               nxt_st.actual = st_ff.actual - 8'h01;
            end
         end
         // Minimum follows only once the ramp has settled
         if (nxt_st.ramp_done && (nxt_st.actual < st_ff.minimum)) begin
            nxt_st.minimum = nxt_st.actual;
         end
         if (timed_out || level_end) begin
            nxt_st.out_on = 1'b0;
            nxt_st.mode = lfc_pkg::M_STANDBY;
            if (timed_out && !(st_ff.strobe_on && !st_ff.strobe_type)) begin
               nxt_st.flt_timeout = 1'b1;
            end
         end
      end

      // Sink drive follows the registered mode
      case (st_ff.mode)
         lfc_pkg::M_TORCH, lfc_pkg::M_ASSIST: begin
            nxt_st.sink_code = {1'b0, st_ff.led_cur[6:0]};
            nxt_st.sink_en = 1'b1;
         end
         lfc_pkg::M_INDICATOR: begin
            nxt_st.sink_code = {2'b00, st_ff.led_cur[5:0]};
            nxt_st.sink_en = pwm_on;
         end
         lfc_pkg::M_FLASH_ON: begin
            nxt_st.sink_code = st_ff.actual;
            nxt_st.sink_en = 1'b1;
         end
         default: begin
            nxt_st.sink_code = 8'h00;
            nxt_st.sink_en = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
         st_ff.mode <= lfc_pkg::M_STANDBY;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign current_sink_outputs = st_ff.sink_code;
   assign sink_on = st_ff.sink_en;
   assign op_mode = st_ff.mode;
endmodule

// ===== hdl/lfc_pin_if.sv
`timescale 1ns/100ps
// Pin levels after synchronisation, shared by the synchroniser and the core
interface lfc_pin_if;
   logic scl;
   logic trig;
   logic mask;
   logic vin_pre_low;
   logic vin_run_low;
   modport sync_side (output scl, output trig, output mask, output vin_pre_low,
      output vin_run_low);
   modport core_side (input scl, input trig, input mask, input vin_pre_low,
      input vin_run_low);
endinterface

// ===== hdl/lfc_pin_sync.sv
`timescale 1ns/100ps
module lfc_pin_sync #(
   parameter int W = 5
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [W-1:0] raw,
   lfc_pin_if.sync_side pins
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } lfc_sync_type;

   lfc_sync_type st_ff;
   lfc_sync_type nxt_st;

   // Two stages; only the second stage drives the pin levels
   always_comb begin
      nxt_st.s1 = raw;
      nxt_st.s2 = st_ff.s1;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pins.scl = st_ff.s2[0];
   assign pins.trig = st_ff.s2[1];
   assign pins.mask = st_ff.s2[2];
   assign pins.vin_pre_low = st_ff.s2[3];
   assign pins.vin_run_low = st_ff.s2[4];
endmodule

// ===== hdl/lfc_pkg.sv
package lfc_pkg;

   // ---------------------------------------------------------------
   // Register map (byte addresses on APB)
   // ---------------------------------------------------------------
   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] CURRENT_OFS = 12'h004;
   localparam logic [11:0] TIMING_OFS = 12'h008;
   localparam logic [11:0] STATUS_OFS = 12'h00c;
   localparam logic [11:0] FAULT_OFS = 12'h010;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_OUT_ON_POS = 0;
   localparam int CTRL_MODE_POS = 1;
   localparam int CTRL_PIN_FN_POS = 3;
   localparam int CTRL_STROBE_ON_POS = 5;
   localparam int CTRL_STROBE_TYPE_POS = 6;
   localparam int CTRL_ABORT_POS = 7;
   localparam int CUR_LED_POS = 0;
   localparam int CUR_MASK_POS = 8;
   localparam int TIM_LIMIT_POS = 0;
   localparam int TIM_DUTY_POS = 8;
   localparam int STAT_ACTUAL_POS = 0;
   localparam int STAT_MIN_POS = 8;
   localparam int STAT_MODE_POS = 16;
   localparam int FLT_UVLO_POS = 0;
   localparam int FLT_TIMEOUT_POS = 1;
   localparam int FLT_MASK_POS = 2;

   // ---------------------------------------------------------------
   // Reset values of the configuration fields
   // ---------------------------------------------------------------
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic [1:0] PIN_FN_RST = 2'h0;
   localparam logic [7:0] LED_CUR_RST = 8'h00;
   localparam logic [7:0] MASK_CUR_RST = 8'h00;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam logic [3:0] DUTY_RST = 4'h0;

   // Encodings of the mode select and pin function fields
   localparam logic [1:0] MODE_IND = 2'h1;
   localparam logic [1:0] MODE_ASSIST = 2'h2;
   localparam logic [1:0] MODE_FLASH = 2'h3;
   localparam logic [1:0] PIN_FN_MASK = 2'h1;
   localparam logic [1:0] PIN_FN_TORCH = 2'h2;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 20;
   localparam int IDLE_TIME_NS = 100_000_000;
   localparam int IDLE_CYCLES = IDLE_TIME_NS / CLK_PERIOD_NS;
   localparam int STEP_TIME_NS = 8_000;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PWM_PERIOD_NS = 32_000;
   localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PWM_STEPS = 16;
   localparam int PWM_SLOT_CYCLES = PWM_PERIOD_CYCLES / PWM_STEPS;
   localparam int FLASH_UNIT_NS = 1_000_000;
   localparam int FLASH_UNIT_CYCLES = FLASH_UNIT_NS / CLK_PERIOD_NS;

   // Operating modes as seen at the sinks
   typedef enum logic [2:0] {
      M_SHUTDOWN = 3'h0,
      M_STANDBY = 3'h1,
      M_TORCH = 3'h2,
      M_INDICATOR = 3'h3,
      M_ASSIST = 3'h4,
      M_FLASH_ARM = 3'h5,
      M_FLASH_ON = 3'h6
   } lfc_mode_type;

endpackage

// ===== hdl/lfc_pwm.sv
`timescale 1ns/100ps
module lfc_pwm #(
   parameter int PERIOD = lfc_pkg::PWM_PERIOD_CYCLES,
   parameter int SLOT = lfc_pkg::PWM_SLOT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [3:0] duty,
   output logic pwm_on
);
   typedef struct packed {
      logic [15:0] cnt;
      logic on;
   } lfc_pwm_type;

   lfc_pwm_type st_ff;
   lfc_pwm_type nxt_st;

   // Free-running period; duty code n gives (n+1)/16 on-time
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.cnt == 16'(PERIOD - 1)) begin
         nxt_st.cnt = 16'h0000;
      end else begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
      nxt_st.on = (nxt_st.cnt < 16'((32'(duty) + 32'h1) * 32'(SLOT)));
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pwm_on = st_ff.on;
endmodule

// ===== verif/lfc_core_checker.sv
`timescale 1ns/100ps
module lfc_core_checker (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_in,
   input wire logic [7:0] current_sink_outputs,
   input wire logic sink_on,
   input wire logic [2:0] op_mode
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   // Two cycles in a mode, so the sink stage has caught up
   sequence s_held(logic [2:0] m);
      (op_mode == m) [*2];
   endsequence
   sequence s_wake;
      (op_mode == lfc_pkg::M_SHUTDOWN) ##0 scl_in [*6];
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_ready;
      pready;
   endproperty
   property p_err;
      pslverr |-> psel && penable;
   endproperty
   property p_shut;
      s_held(lfc_pkg::M_SHUTDOWN) |-> !sink_on;
   endproperty
   property p_standby;
      s_held(lfc_pkg::M_STANDBY) |-> !sink_on;
   endproperty
   property p_torch;
      s_held(lfc_pkg::M_TORCH) |-> !current_sink_outputs[7];
   endproperty
   property p_assist;
      s_held(lfc_pkg::M_ASSIST) |-> !current_sink_outputs[7];
   endproperty
   property p_ind;
      s_held(lfc_pkg::M_INDICATOR) |-> current_sink_outputs[7:6] == 2'h0;
   endproperty
   property p_flash;
      s_held(lfc_pkg::M_FLASH_ON) |-> sink_on;
   endproperty
   property p_wake;
      s_wake |-> op_mode != lfc_pkg::M_SHUTDOWN;
   endproperty
   a_ready: assert property (p_ready) else $error("ready dropped");
   a_err: assert property (p_err) else $error("error outside access");
   a_shut: assert property (p_shut) else $error("sink on in shutdown");
   a_standby: assert property (p_standby) else $error("sink on in standby");
   a_torch: assert property (p_torch) else $error("torch top bit used");
   a_assist: assert property (p_assist) else $error("assist top bit used");
   a_ind: assert property (p_ind) else $error("indicator high bits used");
   a_flash: assert property (p_flash) else $error("sink off in flash");
   a_wake: assert property (p_wake) else $error("no wake on clock high");
endmodule
bind lfc_core lfc_core_checker i_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
   .penable(penable), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
   .current_sink_outputs(current_sink_outputs), .sink_on(sink_on), .op_mode(op_mode));

// ===== verif/lfc_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Host side: clock line and battery monitor
// ----------------------------------------
module lfc_host_model (
   input wire logic scl_alive,
   input wire logic [7:0] vbat,
   input wire logic [7:0] thr_pre,
   input wire logic [7:0] thr_run,
   output logic scl,
   output logic vin_pre_low,
   output logic vin_run_low
);
   // A powered-down host lets its clock line sink low; a live idle bus sits high
   assign scl = scl_alive;
   // Thresholds come from the host, so a short test flash can use a stricter one
   assign vin_pre_low = vbat < thr_pre;
   assign vin_run_low = vbat < thr_run;
endmodule

// ===== verif/tb_led_flash_mode_current_control.sv
`timescale 1ns/100ps
module tb_led_flash_mode_current_control;
   localparam logic [11:0] RCTL = lfc_pkg::CTRL_OFS;
   localparam logic [11:0] RCUR = lfc_pkg::CURRENT_OFS;
   localparam logic [11:0] RSTA = lfc_pkg::STATUS_OFS;
   localparam logic [11:0] RFLT = lfc_pkg::FAULT_OFS;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic trig = 1'b0, mask = 1'b0, scl_alive = 1'b1;
   logic [7:0] vbat = 8'h80, thr_pre = 8'h40, thr_run = 8'h60, code;
   logic pready, pslverr, scl, vpl, vrl, sink_on;
   logic [2:0] op_mode;
   logic [7:0] tc[6] = '{8'h00, 8'h08, 8'h02, 8'h03, 8'h05, 8'h10};
   logic [2:0] tm[6] = '{3'h1, 3'h1, 3'h1, 3'h3, 3'h4, 3'h2};
   int mismatches = 0, checks = 0, cyc = 0, n;
   always #10 ref_clk = ~ref_clk;
   lfc_host_model i_host (.scl_alive(scl_alive), .vbat(vbat), .thr_pre(thr_pre),
      .thr_run(thr_run), .scl(scl), .vin_pre_low(vpl), .vin_run_low(vrl));
   lfc_core #(.IDLE_CYCLES(50), .FLASH_UNIT_CYCLES(20)) i_dut (.ref_clk(ref_clk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl), .trigger_in(trig), .mask_torch_in(mask), .vin_pre_low_in(vpl),
      .vin_run_low_in(vrl), .current_sink_outputs(code), .sink_on(sink_on),
      .op_mode(op_mode));
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request held until pready is seen high with the access phase
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   // Bounded waits on the design's own outputs
   task automatic mode_in(input logic [2:0] m, input int max);
      for (n = 0; op_mode !== m && n < max; n++) @(posedge ref_clk);
      chk({29'h0, op_mode}, {29'h0, m});
   endtask
   task automatic code_in(input logic [7:0] c, input int max);
      for (n = 0; code !== c && n < max; n++) @(posedge ref_clk);
      chk({24'h0, code}, {24'h0, c});
   endtask
   // Hang guard, well above the longest expected run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rdchk(RSTA, 32'h0001_0000);
      apb(1'b1, 12'h014, 32'hff);
      chk(err, 1'b1);
      rdchk(12'h014, 32'h0);
      // Mode table, mask pin high throughout so the torch-function entry selects torch
      apb(1'b1, RCUR, 32'hff);
      mask <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, RCTL, {24'h0, tc[i]});
         mode_in(tm[i], 8);
      end
      // Indicator duty over one whole PWM period
      apb(1'b1, lfc_pkg::TIMING_OFS, 32'h0300);
      apb(1'b1, RCTL, 32'h03);
      mode_in(3'h3, 8);
      n = 0;
      repeat (lfc_pkg::PWM_PERIOD_CYCLES) @(posedge ref_clk) n += int'(sink_on === 1'b1);
      chk(n, 4 * lfc_pkg::PWM_SLOT_CYCLES);
      // Host goes quiet, then wakes the part
      mask <= 1'b0;
      scl_alive <= 1'b0;
      mode_in(3'h0, 80);
      rdchk(RCTL, 32'h0);
      rdchk(RCUR, 32'h0);
      scl_alive <= 1'b1;
      mode_in(3'h1, 6);
      // Flash on enable, ramp cadence and readbacks
      apb(1'b1, RCUR, 32'h03);
      apb(1'b1, lfc_pkg::TIMING_OFS, 32'h63);
      apb(1'b1, RCTL, 32'h07);
      mode_in(3'h6, 4);
      code_in(8'h01, 420);
      for (n = 0; code === 8'h01 && n < 500; n++) @(posedge ref_clk);
      chk(n, lfc_pkg::STEP_CYCLES);
      code_in(8'h03, 420);
      rdchk(RSTA, 32'h0006_0303);
      mode_in(3'h1, 2100);
      rdchk(RCTL, 32'h06);
      rdchk(RFLT, 32'h2);
      rdchk(RFLT, 32'h0);
      // Short test flash with a stricter running threshold, battery sags
      apb(1'b1, RCUR, 32'h02);
      apb(1'b1, RCTL, 32'h07);
      code_in(8'h02, 900);
      vbat <= 8'h50;
      code_in(8'h01, 420);
      vbat <= 8'h80;
      mode_in(3'h1, 2100);
      apb(1'b0, RSTA, 32'h0);
      chk(rd[15:8], 8'h01);
      rdchk(RFLT, 32'h3);
      // Weak battery before start: abort, then run at the reduced level
      thr_run <= 8'h20;
      vbat <= 8'h30;
      apb(1'b1, RCTL, 32'h87);
      repeat (10) @(posedge ref_clk);
      chk({29'h0, op_mode}, 32'h1);
      rdchk(RCTL, 32'h86);
      rdchk(RFLT, 32'h1);
      apb(1'b1, RCUR, 32'h0103);
      apb(1'b1, RCTL, 32'h07);
      code_in(8'h01, 900);
      repeat (900) @(posedge ref_clk);
      chk({24'h0, code}, 32'h01);
      mode_in(3'h1, 2100);
      vbat <= 8'h80;
      apb(1'b0, RFLT, 32'h0);
      // Edge trigger: armed, fires, keeps going after the pin drops
      apb(1'b1, RCTL, 32'h27);
      repeat (8) @(posedge ref_clk);
      chk({29'h0, op_mode}, 32'h5);
      trig <= 1'b1;
      mode_in(3'h6, 6);
      trig <= 1'b0;
      repeat (20) @(posedge ref_clk);
      chk({29'h0, op_mode}, 32'h6);
      mode_in(3'h1, 2100);
      // Level trigger ends with the pin
      apb(1'b1, RCTL, 32'h67);
      trig <= 1'b1;
      mode_in(3'h6, 6);
      repeat (100) @(posedge ref_clk);
      trig <= 1'b0;
      mode_in(3'h1, 6);
      // Radio mask clamps the flash to the reduced level
      mask <= 1'b1;
      apb(1'b0, RFLT, 32'h0);
      apb(1'b1, RCTL, 32'h0f);
      mode_in(3'h6, 4);
      code_in(8'h01, 900);
      repeat (900) @(posedge ref_clk);
      chk({24'h0, code}, 32'h01);
      mode_in(3'h1, 2100);
      rdchk(RFLT, 32'h6);
      // Level trigger held past a one-unit limit: the timer still ends it
      apb(1'b1, lfc_pkg::TIMING_OFS, 32'h00);
      apb(1'b1, RCTL, 32'h67);
      trig <= 1'b1;
      mode_in(3'h6, 6);
      mode_in(3'h1, 30);
      rdchk(RFLT, 32'h2);
      complete_run();
   end
endmodule
